//--- rtl/clock_output_divider_delay.sv
// clock output bank with request handling, follower start and register slave
//
// Added by the designer: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
module clock_output_divider_delay #(
  parameter int N_OUT = 11
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register bus write address
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  // register bus write data
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // register bus write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // register bus read address
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  // register bus read data
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // pins
  input wire logic sync_request_input,
  input wire logic follower_clk_in,
  output logic [N_OUT-1:0] clk_out
);

  //////////////////////////////////////////////////////////////////////////
  // control state

  logic software_request_bit;
  logic request_mode_select;
  logic [clk_out_pkg::EXP_W-1:0] pulse_count_exponent;
  logic follower_mode;
  clk_out_pkg::chan_cfg_t cfg [N_OUT];
  clk_out_pkg::chan_req_t req;
  logic [N_OUT-1:0] running;
  logic [N_OUT-1:0] levels;

  // bus holding registers
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic do_write;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  logic [1:0] next_bresp;

  // request path
  logic [2:0] req_pin_sync;
  logic pin_level;
  logic req_prev;
  logic req_comb;
  logic req_rise;
  logic [2:0] fclk_sync;
  logic fclk_level;
  logic fclk_prev;
  logic follow_wait;
  logic [clk_out_pkg::FCNT_W-1:0] follow_cnt;

  //////////////////////////////////////////////////////////////////////////
  // request pin: three stages, level moves once stages two and three agree

  always_ff @(posedge clk) begin
    if (rst) begin
      req_pin_sync <= 3'h0;
      pin_level <= 1'b0;
    end else begin
      req_pin_sync <= {req_pin_sync[1:0], sync_request_input};
      if (req_pin_sync[1] == req_pin_sync[2]) begin
        pin_level <= req_pin_sync[2];
      end
    end
  end

  // software bit and pin share one request; the rising edge is the event
  assign req_comb = pin_level | software_request_bit;
  assign req_rise = req_comb & !req_prev;

  always_ff @(posedge clk) begin
    if (rst) begin
      req_prev <= 1'b0;
    end else begin
      req_prev <= req_comb;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // follower start: count driver clock pulses after a sync

  always_ff @(posedge clk) begin
    if (rst) begin
      fclk_sync <= 3'h0;
      fclk_level <= 1'b0;
      fclk_prev <= 1'b0;
    end else begin
      fclk_sync <= {fclk_sync[1:0], follower_clk_in};
      if (fclk_sync[1] == fclk_sync[2]) begin
        fclk_level <= fclk_sync[2];
      end
      fclk_prev <= fclk_level;
    end
  end

  // the driver clock must be slow enough to be sampled at this clock rate
  always_ff @(posedge clk) begin
    if (rst) begin
      follow_wait <= 1'b0;
      follow_cnt <= '0;
    end else if (req_rise && !request_mode_select && follower_mode) begin
      follow_wait <= 1'b1;
      follow_cnt <= '0;
    end else if (follow_wait && fclk_level && !fclk_prev) begin
      follow_cnt <= follow_cnt + 1'b1;
      if (follow_cnt == clk_out_pkg::FOLLOW_PULSES - 1'b1) begin
        follow_wait <= 1'b0;
      end
    end
  end

  // request events fan out to every channel in the same cycle
  always_comb begin
    req.sync = req_rise & !request_mode_select;
    req.sysref = req_rise & request_mode_select;
    req.level = req_comb;
    req.hold = follow_wait;
    req.exponent = pulse_count_exponent;
  end

  //////////////////////////////////////////////////////////////////////////
  // output channels

  genvar i;
  generate
    for (i = 0; i < N_OUT; i++) begin : g_chan
      // per-channel settings written from the bus
      always_ff @(posedge clk) begin
        if (rst) begin
          cfg[i].divide <= clk_out_pkg::DIV_RST;
          cfg[i].delay <= clk_out_pkg::DLY_RST;
          cfg[i].func <= clk_out_pkg::FUNC_RST;
          cfg[i].accept <= clk_out_pkg::ACCEPT_RST;
        end else if (do_write && next_bresp == clk_out_pkg::RESP_OKAY &&
                     wr_addr >= clk_out_pkg::CHAN_BASE &&
                     wr_addr[7:4] - clk_out_pkg::CHAN_BASE_IDX == 4'(i)) begin
          case (wr_addr[3:2])
            clk_out_pkg::CHAN_DIV_SEL: cfg[i].divide <= clk_out_pkg::DIV_W'(
                clk_out_pkg::merge_strb(32'(cfg[i].divide), wr_data, wr_strb));
            clk_out_pkg::CHAN_DLY_SEL: cfg[i].delay <= clk_out_pkg::DLY_W'(
                clk_out_pkg::merge_strb(32'(cfg[i].delay), wr_data, wr_strb));
            clk_out_pkg::CHAN_CFG_SEL: begin
              if (wr_strb[0]) begin
                cfg[i].func <= wr_data[clk_out_pkg::CFG_FUNC_LSB +: 2];
                cfg[i].accept <= wr_data[clk_out_pkg::CFG_ACCEPT_BIT];
              end
            end
            default: begin
            end
          endcase
        end
      end

      clk_out_channel u_chan (
        .clk(clk),
        .rst(rst),
        .cfg(cfg[i]),
        .req(req),
        .out(levels[i]),
        .running(running[i])
      );
    end
  endgenerate

  // channel outputs are already registered inside each channel
  assign clk_out = levels;

  //////////////////////////////////////////////////////////////////////////
  // global control word

  always_ff @(posedge clk) begin
    if (rst) begin
      software_request_bit <= 1'b0;
      request_mode_select <= 1'b0;
      pulse_count_exponent <= clk_out_pkg::EXP_RST;
      follower_mode <= 1'b0;
    end else if (do_write && wr_addr == clk_out_pkg::CTRL_OFS) begin
      if (wr_strb[0]) begin
        software_request_bit <= wr_data[clk_out_pkg::CTRL_SWREQ_BIT];
        request_mode_select <= wr_data[clk_out_pkg::CTRL_MODE_BIT];
        pulse_count_exponent <= wr_data[clk_out_pkg::CTRL_EXP_LSB +: clk_out_pkg::EXP_W];
      end
      if (wr_strb[1]) begin
        follower_mode <= wr_data[clk_out_pkg::CTRL_FOLLOW_BIT];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // register bus write side: address and data in either order

  assign do_write = !awready && !wready && !bvalid;

  always_ff @(posedge clk) begin
    if (rst) begin
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= clk_out_pkg::RESP_OKAY;
      wr_addr <= 8'h00;
      wr_data <= 32'h0000_0000;
      wr_strb <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        awready <= 1'b0;
        wr_addr <= awaddr;
      end
      if (wvalid && wready) begin
        wready <= 1'b0;
        wr_data <= wdata;
        wr_strb <= wstrb;
      end
      if (do_write) begin
        bvalid <= 1'b1;
        bresp <= next_bresp;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // writable map: control word and channel words; status words refuse writes
  always_comb begin
    next_bresp = clk_out_pkg::RESP_SLVERR;
    if (wr_addr[1:0] != 2'h0) begin
      next_bresp = clk_out_pkg::RESP_SLVERR;
    end else if (wr_addr == clk_out_pkg::CTRL_OFS) begin
      next_bresp = clk_out_pkg::RESP_OKAY;
    end else if (wr_addr >= clk_out_pkg::CHAN_BASE &&
                 wr_addr[7:4] - clk_out_pkg::CHAN_BASE_IDX < 4'(N_OUT) &&
                 wr_addr[3:2] != 2'h3) begin
      next_bresp = clk_out_pkg::RESP_OKAY;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // register bus read side: answer one cycle after the address is taken

  always_comb begin
    logic [3:0] idx;
    idx = araddr[7:4] - clk_out_pkg::CHAN_BASE_IDX;
    next_rdata = 32'h0000_0000;
    next_rresp = clk_out_pkg::RESP_OKAY;
    if (araddr == clk_out_pkg::CTRL_OFS) begin
      next_rdata[clk_out_pkg::CTRL_SWREQ_BIT] = software_request_bit;
      next_rdata[clk_out_pkg::CTRL_MODE_BIT] = request_mode_select;
      next_rdata[clk_out_pkg::CTRL_EXP_LSB +: clk_out_pkg::EXP_W] = pulse_count_exponent;
      next_rdata[clk_out_pkg::CTRL_FOLLOW_BIT] = follower_mode;
    end else if (araddr == clk_out_pkg::STATUS_OFS) begin
      next_rdata[0] = req_comb;
      next_rdata[1] = follow_wait;
      next_rdata[4 +: clk_out_pkg::FCNT_W] = follow_cnt;
    end else if (araddr == clk_out_pkg::RUN_OFS) begin
      next_rdata[N_OUT-1:0] = running;
    end else if (araddr == clk_out_pkg::LEVEL_OFS) begin
      next_rdata[N_OUT-1:0] = levels;
    end else if (araddr >= clk_out_pkg::CHAN_BASE && idx < 4'(N_OUT) &&
                 araddr[1:0] == 2'h0) begin
      case (araddr[3:2])
        clk_out_pkg::CHAN_DIV_SEL: next_rdata[clk_out_pkg::DIV_W-1:0] = cfg[idx].divide;
        clk_out_pkg::CHAN_DLY_SEL: next_rdata[clk_out_pkg::DLY_W-1:0] = cfg[idx].delay;
        clk_out_pkg::CHAN_CFG_SEL: begin
          next_rdata[clk_out_pkg::CFG_FUNC_LSB +: 2] = cfg[idx].func;
          next_rdata[clk_out_pkg::CFG_ACCEPT_BIT] = cfg[idx].accept;
        end
        default: next_rresp = clk_out_pkg::RESP_SLVERR;
      endcase
    end else begin
      next_rresp = clk_out_pkg::RESP_SLVERR; // unmapped reads as zero with an error
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= clk_out_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

endmodule

//--- rtl/clk_out_pkg.sv
// shared constants, types and helpers for the clock output divider and delay block
//////////////////////////////////////////////////////////////////////////////
// What this block does
// - function select 0 clock, 1 or 3 SYSREF, 2 request passthrough.
// - function select 3 gives a finite pulse burst per request, otherwise low.
// - request accept enable at 0 ignores all requests; function 0 and 1 outputs keep running freely, passthrough stays low.
// - each delay code unit shifts the output by half a VCO period.
// - output frequency is VCO frequency over the output divide value.
// - follower waits seven follower-driver pulses before its outputs start running.
// - request mode select 0 means output sync, 1 means SYSREF pulse request.
// - pulsed SYSREF emits two to the pulse count exponent pulses, then low.
//////////////////////////////////////////////////////////////////////////////
package clk_out_pkg;

  // field widths
  localparam int DIV_W = 12;
  localparam int DLY_W = 12;
  localparam int EXP_W = 3;
  localparam int BURST_W = 8;
  localparam int FCNT_W = 3;

  // register offsets (byte addresses)
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] RUN_OFS = 8'h08;
  localparam logic [7:0] LEVEL_OFS = 8'h0c;
  localparam logic [7:0] CHAN_BASE = 8'h40;
  localparam logic [3:0] CHAN_BASE_IDX = 4'h4;
  localparam logic [1:0] CHAN_DIV_SEL = 2'h0;
  localparam logic [1:0] CHAN_DLY_SEL = 2'h1;
  localparam logic [1:0] CHAN_CFG_SEL = 2'h2;

  // control word fields
  localparam int CTRL_SWREQ_BIT = 0;
  localparam int CTRL_MODE_BIT = 1;
  localparam int CTRL_EXP_LSB = 4;
  localparam int CTRL_FOLLOW_BIT = 8;

  // channel config word fields
  localparam int CFG_FUNC_LSB = 0;
  localparam int CFG_ACCEPT_BIT = 2;

  // reset values
  localparam logic [DIV_W-1:0] DIV_RST = 12'h001;
  localparam logic [DLY_W-1:0] DLY_RST = 12'h000;
  localparam logic [1:0] FUNC_RST = 2'h0;
  localparam logic ACCEPT_RST = 1'b1;
  localparam logic [EXP_W-1:0] EXP_RST = 3'h0;

  // output function select codes
  localparam logic [1:0] FUNC_CLOCK = 2'h0;
  localparam logic [1:0] FUNC_SYSREF = 2'h1;
  localparam logic [1:0] FUNC_PASS = 2'h2;
  localparam logic [1:0] FUNC_PULSED = 2'h3;

  // follower start waits this many driver pulses
  localparam logic [FCNT_W-1:0] FOLLOW_PULSES = 3'h7;

  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // per-output settings
  typedef struct packed {
    logic [DIV_W-1:0] divide;
    logic [DLY_W-1:0] delay;
    logic [1:0] func;
    logic accept;
  } chan_cfg_t;

  // request events shared by all outputs
  typedef struct packed {
    logic sync;
    logic sysref;
    logic level;
    logic hold;
    logic [EXP_W-1:0] exponent;
  } chan_req_t;

  // byte-lane merge for bus writes
  function automatic logic [31:0] merge_strb(input logic [31:0] old, input logic [31:0] data,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = data[b*8 +: 8];
      end
    end
    return res;
  endfunction

endpackage

//--- rtl/clk_out_channel.sv
// one output channel: divider, half-cycle delay, burst and passthrough logic
`timescale 1ns/1ps
module clk_out_channel (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // settings and request events
  input wire clk_out_pkg::chan_cfg_t cfg,
  input wire clk_out_pkg::chan_req_t req,
  // channel state
  output logic out,
  output logic running
);

  logic [clk_out_pkg::DIV_W:0] phase;
  logic [clk_out_pkg::DIV_W-1:0] eff_div;
  logic [clk_out_pkg::DLY_W-1:0] dly_left;
  logic waiting;
  logic div_high;
  logic period_end;
  logic sync_hit;
  logic armed;
  logic bursting;
  logic [clk_out_pkg::BURST_W-1:0] pulses_left;
  logic pass_level;
  logic pass_busy;
  logic [clk_out_pkg::DLY_W-1:0] pass_left;

  // a zero divide would never toggle, so treat it as one
  assign eff_div = (cfg.divide == '0) ? clk_out_pkg::DIV_RST : cfg.divide;
  // high for divide half-VCO steps, low for the same
  assign div_high = phase < {1'b0, eff_div};
  // at or past the end, so a smaller divide written mid-period cannot run the phase to wrap
  assign period_end = phase >= ({eff_div, 1'b0} - 1'b1);
  assign sync_hit = req.sync & cfg.accept;

  // sync restart and delay countdown, held while a follower waits
  always_ff @(posedge clk) begin
    if (rst) begin
      waiting <= 1'b0;
      dly_left <= '0;
    end else if (sync_hit) begin
      waiting <= 1'b1;
      dly_left <= cfg.delay;
    end else if (waiting && !req.hold) begin
      if (dly_left == '0) begin
        waiting <= 1'b0;
      end else begin
        dly_left <= dly_left - 1'b1;
      end
    end
  end

  // divider phase, one step per half VCO period
  always_ff @(posedge clk) begin
    if (rst || sync_hit || waiting) begin
      phase <= '0;
    end else if (period_end) begin
      phase <= '0;
    end else begin
      phase <= phase + 1'b1;
    end
  end

  // pulse burst starts on a period boundary so no runt pulse leaves
  always_ff @(posedge clk) begin
    if (rst || sync_hit) begin
      armed <= 1'b0;
      bursting <= 1'b0;
      pulses_left <= '0;
    end else if (req.sysref && cfg.accept && cfg.func == clk_out_pkg::FUNC_PULSED) begin
      armed <= 1'b1;
      bursting <= 1'b0;
      pulses_left <= clk_out_pkg::BURST_W'(1) << req.exponent;
    end else if (bursting && period_end) begin
      pulses_left <= pulses_left - 1'b1;
      if (pulses_left == clk_out_pkg::BURST_W'(1)) begin
        bursting <= 1'b0;
      end
    end else if (armed && period_end && !waiting) begin
      armed <= 1'b0;
      bursting <= 1'b1;
    end
  end

  // passthrough copies each request level change after the delay code
  always_ff @(posedge clk) begin
    if (rst || !cfg.accept) begin
      pass_level <= 1'b0;
      pass_busy <= 1'b0;
      pass_left <= '0;
    end else if (pass_busy) begin
      if (pass_left == '0) begin
        pass_level <= req.level;
        pass_busy <= 1'b0;
      end else begin
        pass_left <= pass_left - 1'b1;
      end
    end else if (req.level != pass_level) begin
      pass_busy <= 1'b1;
      pass_left <= cfg.delay;
    end
  end

  // output selection, one register stage for every function
  always_ff @(posedge clk) begin
    if (rst) begin
      out <= 1'b0;
    end else begin
      case (cfg.func)
        clk_out_pkg::FUNC_CLOCK: out <= div_high & !waiting;
        clk_out_pkg::FUNC_SYSREF: out <= div_high & !waiting;
        clk_out_pkg::FUNC_PASS: out <= pass_level;
        clk_out_pkg::FUNC_PULSED: out <= div_high & bursting & !waiting;
        default: out <= 1'b0;
      endcase
    end
  end

  // running flag for status readback
  always_ff @(posedge clk) begin
    if (rst) begin
      running <= 1'b0;
    end else begin
      running <= !waiting;
    end
  end

endmodule

//--- sim/clock_output_divider_delay_chk.sv
// bus handshake and reset checks for the clock output bank
`timescale 1ns/1ps
module clock_output_divider_delay_chk #(
  parameter int N_OUT = 11
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // write channels
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  // read channels
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic rvalid,
  input wire logic rready,
  // outputs
  input wire logic [N_OUT-1:0] clk_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  //////////////////////////////////////////////////////////////////////////////
  // write side: one transfer at a time, answer within a short bound
  property p_aw_close; awvalid && awready |=> !awready; endproperty
  a_aw_close: assert property (p_aw_close) else $error("awready high after address taken");
  property p_w_close; wvalid && wready |=> !wready; endproperty
  a_w_close: assert property (p_w_close) else $error("wready high after data taken");
  property p_b_time; awvalid && awready && wvalid && wready |=> !bvalid ##[1:2] bvalid; endproperty
  a_b_time: assert property (p_b_time) else $error("write answer late or early");
  property p_b_hold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped early");
  property p_b_done; bvalid && bready |=> !bvalid ##[0:1] (awready && wready); endproperty
  a_b_done: assert property (p_b_done) else $error("write side not reopened");
  // read side: answer within two edges and held until taken
  property p_r_time; arvalid && arready |-> ##[1:2] rvalid; endproperty
  a_r_time: assert property (p_r_time) else $error("read answer late");
  property p_r_hold; rvalid && !rready |=> rvalid && $stable(rdata); endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped early");
  property p_r_block; rvalid |-> !arready; endproperty
  a_r_block: assert property (p_r_block) else $error("second read accepted");
  // outputs quiet right after reset
  property p_rst_out; $fell(rst) |-> clk_out == '0 && !bvalid && !rvalid; endproperty
  a_rst_out: assert property (p_rst_out) else $error("outputs not cleared by reset");
endmodule

bind clock_output_divider_delay clock_output_divider_delay_chk #(.N_OUT(N_OUT)) u_chk (
  .clk(clk), .rst(rst), .awvalid(awvalid), .awready(awready), .wvalid(wvalid),
  .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .arvalid(arvalid),
  .arready(arready), .rdata(rdata), .rvalid(rvalid), .rready(rready), .clk_out(clk_out)
);

//--- sim/sync_source_model.sv
// model of the upstream controller: request pin and follower-driver clock
`timescale 1ns/1ps
module sync_source_model (
  // clock
  input wire logic clk,
  // pins toward the block
  output logic req_pin,
  output logic fol_clk
);
  // both pins idle low; the clock stands still between bursts
  initial begin
    req_pin = 1'b0;
    fol_clk = 1'b0;
  end
  // request level, held as long as the caller wants
  task automatic level(input logic v);
    @(posedge clk);
    req_pin <= v;
  endtask
  // slow pulses, four cycles per level so the input filter sees each one
  task automatic pulses(input int n);
    repeat (n) begin
      repeat (4) @(posedge clk);
      fol_clk <= 1'b1;
      repeat (4) @(posedge clk);
      fol_clk <= 1'b0;
    end
  endtask
endmodule

//--- sim/clock_output_divider_delay_tb.sv
// self-checking bench for the clock output bank
`timescale 1ns/1ps
module clock_output_divider_delay_tb;
  localparam int N = 11;
  localparam int HOLD = 10000; // one millisecond of request hold
  localparam logic [1:0] OK = clk_out_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = clk_out_pkg::RESP_SLVERR;
  localparam logic [7:0] CTRL = clk_out_pkg::CTRL_OFS;
  localparam logic [7:0] RUN = clk_out_pkg::RUN_OFS;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, req_pin, fol_clk;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [N-1:0] clk_out;
  int fail_count = 0;
  int checks = 0;

  always #50 clk = ~clk;

  clock_output_divider_delay #(.N_OUT(N)) u_dut (
    .clk(clk), .rst(rst), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .sync_request_input(req_pin), .follower_clk_in(fol_clk), .clk_out(clk_out)
  );
  sync_source_model u_src (.clk(clk), .req_pin(req_pin), .fol_clk(fol_clk));

  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // bus write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ad;
    logic dd;
    ad = 1'b0;
    dd = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ad && dd)) begin
      @(posedge clk);
      if (!ad && awready) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (!dd && wready) begin
        dd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk("bresp", 32'(er), 32'(bresp));
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    d = rdata;
  endtask
  // channel setup; registers sit at 0x40 plus 0x10 per channel
  task automatic cfgch(input int ch, input logic [11:0] dv, input logic [11:0] dl,
                       input logic [2:0] c);
    logic [7:0] b;
    b = 8'h40 + 8'(ch * 16);
    wr(b, 32'(dv), OK);
    wr(b + 8'h04, 32'(dl), OK);
    wr(b + 8'h08, 32'(c), OK);
  endtask
  // high and low run of one full period, skipping the first
  task automatic period(input int ch, output int hi, output int lo);
    hi = 0;
    lo = 0;
    do @(posedge clk); while (clk_out[ch] !== 1'b0);
    do @(posedge clk); while (clk_out[ch] !== 1'b1);
    while (clk_out[ch] === 1'b1) begin
      hi++;
      @(posedge clk);
    end
    while (clk_out[ch] !== 1'b1) begin
      lo++;
      @(posedge clk);
    end
  endtask
  task automatic rises(input int ch, input int cyc, output int n);
    logic p;
    n = 0;
    p = clk_out[ch];
    repeat (cyc) begin
      @(posedge clk);
      if (clk_out[ch] === 1'b1 && p === 1'b0) n++;
      p = clk_out[ch];
    end
  endtask

  //////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    logic [31:0] d;
    rd(8'h48, d);
    chk("cfg_rst", 32'h4, d);
    rd(8'h40, d);
    chk("div_rst", 32'h1, d);
    rd(8'h4c, d);
    chk("unmapped", 32'h0, d);
    chk("rresp", 32'(ERR), 32'(rresp));
    wr(8'h04, 32'h1, ERR);
  endtask
  task automatic t_divide();
    int dv[5] = '{1, 8, 32, 40, 320};
    int hi;
    int lo;
    foreach (dv[i]) begin
      wr(8'ha0, 32'(dv[i]), OK);
      period(6, hi, lo);
      chk("high", 32'(dv[i]), 32'(hi));
      chk("low", 32'(dv[i]), 32'(lo));
    end
  endtask
  // software sync; passthrough on two channels, phase offset afterwards
  task automatic t_sync();
    logic p;
    int k;
    cfgch(0, 12'd8, 12'd0, 3'h4);
    cfgch(1, 12'd8, 12'(14 * 1 + 0), 3'h4);
    cfgch(2, 12'd8, 12'd0, 3'h2);
    cfgch(5, 12'd8, 12'd5, 3'h6);
    cfgch(3, 12'd4, 12'd0, 3'h7);
    cfgch(4, 12'd4, 12'd0, 3'h5);
    wr(CTRL, 32'h1, OK);
    repeat (50) @(posedge clk);
    chk("pass_on", 32'h1, 32'(clk_out[5]));
    chk("pass_ignored", 32'h0, 32'(clk_out[2]));
    repeat (HOLD) @(posedge clk);
    wr(CTRL, 32'h0, OK);
    repeat (50) @(posedge clk);
    chk("pass_off", 32'h0, 32'(clk_out[5]));
    do @(posedge clk); while (clk_out[0] !== 1'b0);
    do @(posedge clk); while (clk_out[0] !== 1'b1);
    p = 1'b1;
    k = 0;
    while (!(clk_out[1] === 1'b1 && p === 1'b0)) begin
      p = clk_out[1];
      @(posedge clk);
      k++;
    end
    chk("phase", 32'd14, 32'(k));
  endtask
  task automatic t_pulsed();
    int n;
    int m;
    for (int e = 0; e < 3; e += 2) begin
      wr(CTRL, 32'(e << 4) | 32'h2, OK);
      chk("idle_low", 32'h0, 32'(clk_out[3]));
      fork
        wr(CTRL, 32'(e << 4) | 32'h3, OK);
        rises(3, HOLD, n);
        rises(4, HOLD, m);
      join
      wr(CTRL, 32'(e << 4) | 32'h2, OK);
      chk("burst", 32'(1 << e), 32'(n));
      chk("sysref_run", 32'h1, 32'(m >= 1249 && m <= 1251));
    end
  endtask
  // pin sync in follower mode: outputs wait for seven driver pulses
  task automatic t_follower();
    logic [31:0] d;
    wr(CTRL, 32'h100, OK);
    u_src.level(1'b1);
    repeat (20) @(posedge clk);
    u_src.pulses(6);
    repeat (20) @(posedge clk);
    rd(clk_out_pkg::STATUS_OFS, d);
    chk("pulse_count", 32'h6, 32'(d[6:4]));
    rd(RUN, d);
    chk("waiting", 32'h0, 32'(d[0]));
    u_src.pulses(1);
    repeat (20) @(posedge clk);
    rd(RUN, d);
    chk("started", 32'h1, 32'(d[0]));
    u_src.level(1'b0);
  endtask
  // reset again mid-run: settings and outputs go back to their idle values
  task automatic t_reset();
    logic [31:0] d;
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    chk("rst_out", 32'h0, 32'(clk_out));
    rst <= 1'b0;
    rd(CTRL, d);
    chk("rst_ctrl", 32'h0, d);
    rd(8'ha0, d);
    chk("rst_div", 32'h1, d);
    rd(8'h68, d);
    chk("rst_cfg", 32'h4, d);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    if (fail_count == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_divide();
    t_sync();
    t_pulsed();
    t_follower();
    t_reset();
    stop_test();
  end
  // watchdog, about twice the expected run
  initial begin
    repeat (60000) @(posedge clk);
    fail_count++;
    stop_test();
  end
endmodule
